// [rtl/bsap_defines.svh]
`ifndef BSAP_DEFINES_SVH
`define BSAP_DEFINES_SVH

// Window of the bit-addressed space; each step of two selects the next bit.
`define BSAP_CRU_BASE 12'h800
`define BSAP_CRU_LAST 12'h83e

// Input bit positions.
`define BSAP_BIT_RBUF_LAST 5'h07
`define BSAP_BIT_RX_ERR 5'h09
`define BSAP_BIT_RX_PERR 5'h0a
`define BSAP_BIT_RX_OERR 5'h0b
`define BSAP_BIT_RX_FERR 5'h0c
`define BSAP_BIT_RX_FIRST 5'h0d
`define BSAP_BIT_RX_START 5'h0e
`define BSAP_BIT_RX_LINE 5'h0f
`define BSAP_BIT_RX_INT 5'h10
`define BSAP_BIT_TX_INT 5'h11

// Output bit positions.
`define BSAP_BIT_LOW_LAST 5'h0a
`define BSAP_BIT_LD_XRATE 5'h0b
`define BSAP_BIT_LD_RRATE 5'h0c
`define BSAP_BIT_LD_INTV 5'h0d
`define BSAP_BIT_LD_CTRL 5'h0e
`define BSAP_BIT_TEST 5'h0f
`define BSAP_BIT_RTS 5'h10
`define BSAP_BIT_BREAK 5'h11
`define BSAP_BIT_RX_CLEAR 5'h12
`define BSAP_BIT_SW_RESET 5'h1f

// Final bit of each loadable register.
`define BSAP_LAST_CTRL 5'h07
`define BSAP_LAST_INTV 5'h07
`define BSAP_LAST_RATE 5'h0a
`define BSAP_LAST_XBUF 5'h07

// Control register fields.
`define BSAP_CTRL_LEN_LSB 0
`define BSAP_CTRL_ODD 4
`define BSAP_CTRL_PAR_EN 5

// Reset values.
`define BSAP_CTRL_RST 8'h03
`define BSAP_INTV_RST 8'h00
`define BSAP_RATE_RST 11'h010

`endif

// [rtl/bsap_pkg.sv]
package bsap_pkg;

  typedef enum logic [4:0] {
    BSAP_SER_IDLE = 5'h01,
    BSAP_SER_START = 5'h02,
    BSAP_SER_DATA = 5'h04,
    BSAP_SER_PAR = 5'h08,
    BSAP_SER_STOP = 5'h10
  } bsap_ser_state_e;

  typedef struct packed {
    bsap_ser_state_e st;
    logic [10:0] cnt;
    logic [2:0] nbit;
    logic [7:0] shreg;
    logic par;
    logic done;
    logic start_det;
    logic first_det;
    logic perr;
    logic ferr;
  } bsap_rx_s;

  typedef struct packed {
    logic rx_meta;
    logic rx_sync;
    logic [3:0] ld_flags;
    logic test;
    logic rts;
    logic brk;
    logic [7:0] ctrl;
    logic [7:0] intv;
    logic [10:0] rrate;
    logic [10:0] xrate;
    logic [7:0] xbuf;
    logic xfull;
    logic [7:0] rbuf;
    logic rfull;
    logic perr;
    logic oerr;
    logic ferr;
    bsap_ser_state_e tst;
    logic [10:0] tcnt;
    logic [2:0] tbit;
    logic [7:0] tsh;
    logic tpar;
    logic txd;
    logic tx_line;
    logic rdata;
  } bsap_top_s;

endpackage : bsap_pkg

// [rtl/bsap_rx.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bsap_defines.svh"

module bsap_rx (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Line and format.
  input wire logic i_line,
  input wire logic [10:0] i_rate,
  input wire logic [2:0] i_len_m1,
  input wire logic i_par_en,
  input wire logic i_odd,
  // Results.
  output logic [7:0] o_char,
  output logic o_done,
  output logic o_start_det,
  output logic o_first_det,
  output logic o_perr,
  output logic o_ferr
);
  import bsap_pkg::*;

  bsap_rx_s s;
  bsap_rx_s next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (s.st != BSAP_SER_IDLE && s.cnt != 11'h000) begin
      next_s.cnt = s.cnt - 11'h001;
    end else begin
      case (s.st)
        BSAP_SER_IDLE: begin
          if (!i_line) begin
            next_s.st = BSAP_SER_START;
            next_s.cnt = i_rate >> 1;
            next_s.start_det = 1'b1;
            next_s.first_det = 1'b0;
          end
        end
        BSAP_SER_START: begin
          // A start bit gone by mid-bit is a glitch and is dropped.
          if (!i_line) begin
            next_s.st = BSAP_SER_DATA;
            next_s.cnt = i_rate - 11'h001;
            next_s.nbit = 3'h0;
            next_s.par = 1'b0;
          end else begin
            next_s.st = BSAP_SER_IDLE;
            next_s.start_det = 1'b0;
          end
        end
        BSAP_SER_DATA: begin
          next_s.shreg = {i_line, s.shreg[7:1]};
          next_s.par = s.par ^ i_line;
          next_s.first_det = 1'b1;
          next_s.cnt = i_rate - 11'h001;
          next_s.nbit = s.nbit + 3'h1;
          if (s.nbit == i_len_m1) begin
            next_s.st = i_par_en ? BSAP_SER_PAR : BSAP_SER_STOP;
          end
        end
        BSAP_SER_PAR: begin
          next_s.perr = s.par ^ i_line ^ i_odd;
          next_s.cnt = i_rate - 11'h001;
          next_s.st = BSAP_SER_STOP;
        end
        BSAP_SER_STOP: begin
          next_s.ferr = !i_line;
          next_s.done = 1'b1;
          next_s.shreg = s.shreg >> (3'h7 - i_len_m1);
          next_s.start_det = 1'b0;
          next_s.first_det = 1'b0;
          next_s.st = BSAP_SER_IDLE;
        end
        default: begin
          next_s.st = BSAP_SER_IDLE;
        end
      endcase
      if (s.st == BSAP_SER_IDLE || s.st == BSAP_SER_START) begin
        next_s.perr = 1'b0;
        next_s.ferr = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '{st: BSAP_SER_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign o_char = s.shreg;
  assign o_done = s.done;
  assign o_start_det = s.start_det;
  assign o_first_det = s.first_det;
  assign o_perr = s.perr;
  assign o_ferr = s.ferr;

endmodule : bsap_rx

`default_nettype wire

// [rtl/bsap_port.sv]
// Summary of operation
// RULE1 - Answer bit addresses 800 to 83E, one bit per step of two.
// RULE2 - Hold received characters; read them as bits 0 to 7.
// RULE3 - Serialise processor characters with timing and request-to-send handshake.
// RULE4 - Low-bit writes go to control, interval, rates or transmit buffer.
// RULE5 - Output bits 11 to 14 are load flags: tx rate, rx rate, interval, control.
// RULE6 - Bit 15 test mode, bit 16 request-to-send, bit 17 forces break.
// RULE7 - Input bits 9 to 17 report errors, detects, line and interrupts.
// RULE8 - Highest flagged register loads first; its flag clears on its final bit.
`timescale 1ns/1ps
`default_nettype none
`include "bsap_defines.svh"

module bsap_port (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Bit-serial I/O space.
  input wire logic [11:0] i_cru_addr,
  input wire logic i_cru_wr,
  input wire logic i_cru_wdata,
  output logic o_cru_rdata,
  // Terminal link.
  input wire logic i_rx_line,
  output logic o_tx_line,
  output logic o_rts
);
  import bsap_pkg::*;

  bsap_top_s s;
  bsap_top_s next_s;
  logic [7:0] rx_char;
  logic rx_done;
  logic rx_start_det;
  logic rx_first_det;
  logic rx_perr;
  logic rx_ferr;
  logic rx_line;
  logic in_window;
  logic [4:0] bit_sel;
  logic [31:0] rd_bits;
  logic [2:0] len_m1;

  function automatic bsap_top_s reset_state();
    bsap_top_s r;
    r = '{tst: BSAP_SER_IDLE, default: '0};
    r.ctrl = `BSAP_CTRL_RST;
    r.intv = `BSAP_INTV_RST;
    r.rrate = `BSAP_RATE_RST;
    r.xrate = `BSAP_RATE_RST;
    r.txd = 1'b1;
    r.tx_line = 1'b1;
    r.rx_meta = 1'b1;
    r.rx_sync = 1'b1;
    return r;
  endfunction : reset_state

  // In test mode the transmitter feeds the receiver and the pin is ignored.
  assign rx_line = s.test ? s.txd : s.rx_sync; // RULE6
  assign len_m1 = 3'h4 + {1'b0, s.ctrl[`BSAP_CTRL_LEN_LSB +: 2]};
  assign in_window = (i_cru_addr >= `BSAP_CRU_BASE) && (i_cru_addr <= `BSAP_CRU_LAST); // RULE1
  assign bit_sel = i_cru_addr[5:1]; // RULE1

  bsap_rx u_rx (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_line(rx_line),
    .i_rate(s.rrate),
    .i_len_m1(len_m1),
    .i_par_en(s.ctrl[`BSAP_CTRL_PAR_EN]),
    .i_odd(s.ctrl[`BSAP_CTRL_ODD]),
    .o_char(rx_char),
    .o_done(rx_done),
    .o_start_det(rx_start_det),
    .o_first_det(rx_first_det),
    .o_perr(rx_perr),
    .o_ferr(rx_ferr)
  );

  always_comb begin
    rd_bits = 32'h0000_0000;
    rd_bits[`BSAP_BIT_RBUF_LAST:0] = s.rbuf; // RULE2
    rd_bits[`BSAP_BIT_RX_ERR] = s.perr | s.oerr | s.ferr; // RULE7
    rd_bits[`BSAP_BIT_RX_PERR] = s.perr; // RULE7
    rd_bits[`BSAP_BIT_RX_OERR] = s.oerr; // RULE7
    rd_bits[`BSAP_BIT_RX_FERR] = s.ferr; // RULE7
    rd_bits[`BSAP_BIT_RX_FIRST] = rx_first_det; // RULE7
    rd_bits[`BSAP_BIT_RX_START] = rx_start_det; // RULE7
    rd_bits[`BSAP_BIT_RX_LINE] = rx_line; // RULE7
    rd_bits[`BSAP_BIT_RX_INT] = s.rfull; // RULE7
    rd_bits[`BSAP_BIT_TX_INT] = !s.xfull; // RULE7
  end

  always_comb begin
    next_s = s;
    next_s.rx_meta = i_rx_line;
    next_s.rx_sync = s.rx_meta;
    next_s.rdata = in_window ? rd_bits[bit_sel] : 1'b0; // RULE1

    // Transmitter; the counter runs down one bit time per serial bit.
    if (s.tst != BSAP_SER_IDLE && s.tcnt != 11'h000) begin
      next_s.tcnt = s.tcnt - 11'h001;
    end else begin
      case (s.tst)
        BSAP_SER_IDLE: begin
          if (s.xfull) begin
            next_s.tst = BSAP_SER_START; // RULE3
            next_s.tsh = s.xbuf;
            next_s.xfull = 1'b0;
            next_s.txd = 1'b0;
            next_s.tcnt = s.xrate - 11'h001;
            next_s.tbit = 3'h0;
            next_s.tpar = 1'b0;
          end
        end
        BSAP_SER_START, BSAP_SER_DATA: begin
          if (s.tst == BSAP_SER_DATA && s.tbit == len_m1) begin
            next_s.tst = s.ctrl[`BSAP_CTRL_PAR_EN] ? BSAP_SER_PAR : BSAP_SER_STOP;
            next_s.txd = s.ctrl[`BSAP_CTRL_PAR_EN] ? (s.tpar ^ s.ctrl[`BSAP_CTRL_ODD]) : 1'b1;
          end else begin
            next_s.tst = BSAP_SER_DATA; // RULE3
            next_s.txd = s.tsh[0];
            next_s.tpar = s.tpar ^ s.tsh[0];
            next_s.tsh = s.tsh >> 1;
            next_s.tbit = (s.tst == BSAP_SER_START) ? 3'h0 : s.tbit + 3'h1;
          end
          next_s.tcnt = s.xrate - 11'h001;
        end
        BSAP_SER_PAR: begin
          next_s.tst = BSAP_SER_STOP;
          next_s.txd = 1'b1;
          next_s.tcnt = s.xrate - 11'h001;
        end
        BSAP_SER_STOP: begin
          next_s.tst = BSAP_SER_IDLE;
        end
        default: begin
          next_s.tst = BSAP_SER_IDLE;
          next_s.txd = 1'b1;
        end
      endcase
    end

    // Processor writes; software clears come before hardware sets below.
    if (i_cru_wr && in_window) begin // RULE1
      if (bit_sel <= `BSAP_BIT_LOW_LAST) begin
        if (s.ld_flags[3]) begin // RULE4 RULE8
          if (bit_sel <= `BSAP_LAST_CTRL) begin
            next_s.ctrl[bit_sel[2:0]] = i_cru_wdata;
          end
          if (bit_sel == `BSAP_LAST_CTRL) begin
            next_s.ld_flags[3] = 1'b0; // RULE8
          end
        end else if (s.ld_flags[2]) begin // RULE4 RULE8
          if (bit_sel <= `BSAP_LAST_INTV) begin
            next_s.intv[bit_sel[2:0]] = i_cru_wdata;
          end
          if (bit_sel == `BSAP_LAST_INTV) begin
            next_s.ld_flags[2] = 1'b0; // RULE8
          end
        end else if (s.ld_flags[1]) begin // RULE4 RULE8
          next_s.rrate[bit_sel[3:0]] = i_cru_wdata;
          if (bit_sel == `BSAP_LAST_RATE) begin
            next_s.ld_flags[1] = 1'b0; // RULE8
          end
        end else if (s.ld_flags[0]) begin // RULE4 RULE8
          next_s.xrate[bit_sel[3:0]] = i_cru_wdata;
          if (bit_sel == `BSAP_LAST_RATE) begin
            next_s.ld_flags[0] = 1'b0; // RULE8
          end
        end else begin
          if (bit_sel <= `BSAP_LAST_XBUF) begin
            next_s.xbuf[bit_sel[2:0]] = i_cru_wdata; // RULE4
          end
          if (bit_sel == `BSAP_LAST_XBUF) begin
            next_s.xfull = 1'b1; // RULE3
          end
        end
      end else if (bit_sel <= `BSAP_BIT_LD_CTRL) begin
        next_s.ld_flags[bit_sel[1:0] - 2'h3] = i_cru_wdata; // RULE5
      end else if (bit_sel == `BSAP_BIT_TEST) begin
        next_s.test = i_cru_wdata; // RULE6
      end else if (bit_sel == `BSAP_BIT_RTS) begin
        next_s.rts = i_cru_wdata; // RULE6
      end else if (bit_sel == `BSAP_BIT_BREAK) begin
        next_s.brk = i_cru_wdata; // RULE6
      end else if (bit_sel == `BSAP_BIT_RX_CLEAR) begin
        next_s.rfull = 1'b0;
        next_s.perr = 1'b0;
        next_s.oerr = 1'b0;
        next_s.ferr = 1'b0;
      end
    end

    // A character arriving with the clear still wins.
    if (rx_done) begin
      next_s.rbuf = rx_char; // RULE2
      next_s.rfull = 1'b1; // RULE2
      next_s.oerr = s.rfull; // RULE7
      next_s.perr = rx_perr; // RULE7
      next_s.ferr = rx_ferr; // RULE7
    end

    if (i_cru_wr && in_window && bit_sel == `BSAP_BIT_SW_RESET && i_cru_wdata) begin
      next_s = reset_state();
    end

    next_s.tx_line = next_s.brk ? 1'b0 : next_s.txd; // RULE6
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= reset_state();
    end else begin
      s <= next_s;
    end
  end

  assign o_cru_rdata = s.rdata;
  assign o_tx_line = s.tx_line;
  assign o_rts = s.rts; // RULE3

endmodule : bsap_port

`default_nettype wire

// [test/bsap_chk.sv]
`timescale 1ns/1ps
`default_nettype none

module bsap_chk (
  // Watched ports.
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [11:0] i_cru_addr,
  input wire logic i_cru_wr,
  input wire logic i_cru_wdata,
  input wire logic o_cru_rdata,
  input wire logic i_rx_line,
  input wire logic o_tx_line,
  input wire logic o_rts
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  logic brk;
  logic tst;
  logic [10:0] a;
  assign a = i_cru_addr[11:1];
  // Shadow of the break and loop-back bits; a software reset clears both.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      brk <= 1'b0;
      tst <= 1'b0;
    end else if (i_cru_wr && a == 11'h41f && i_cru_wdata) begin
      brk <= 1'b0;
      tst <= 1'b0;
    end else if (i_cru_wr && a == 11'h411) begin
      brk <= i_cru_wdata;
    end else if (i_cru_wr && a == 11'h40f) begin
      tst <= i_cru_wdata;
    end
  end
  property p_outside;
    i_cru_addr[11:6] != 6'h20 |=> !o_cru_rdata;
  endproperty
  a_outside: assert property (p_outside) else $error("read outside window not zero");
  property p_unassigned;
    a == 11'h408 |=> !o_cru_rdata;
  endproperty
  a_unassigned: assert property (p_unassigned) else $error("bit 8 read not zero");
  property p_bit18;
    a == 11'h412 |=> !o_cru_rdata;
  endproperty
  a_bit18: assert property (p_bit18) else $error("bit 18 read not zero");
  property p_rts_set;
    i_cru_wr && a == 11'h410 |=> o_rts == $past(i_cru_wdata);
  endproperty
  a_rts_set: assert property (p_rts_set) else $error("rts does not follow write");
  property p_rts_keep;
    !(i_cru_wr && (a == 11'h410 || a == 11'h41f)) |=> $stable(o_rts);
  endproperty
  a_rts_keep: assert property (p_rts_keep) else $error("rts changed without write");
  property p_brk;
    brk |-> !o_tx_line;
  endproperty
  a_brk: assert property (p_brk) else $error("break not holding line low");
  property p_swrst;
    i_cru_wr && a == 11'h41f && i_cru_wdata |-> ##2 (o_tx_line && !o_rts);
  endproperty
  a_swrst: assert property (p_swrst) else $error("software reset left outputs set");
  property p_line;
    (!tst && i_rx_line) [*4] ##0 a == 11'h40f |=> o_cru_rdata;
  endproperty
  a_line: assert property (p_line) else $error("line level bit wrong");
  property p_rst;
    $rose(i_resetn) |-> o_tx_line && !o_rts;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
endmodule : bsap_chk

`default_nettype wire

// [test/bsap_term.sv]
`timescale 1ns/1ps
`default_nettype none

module bsap_term (
  // Clock.
  input wire logic i_clk_sys,
  // Serial lines.
  input wire logic i_tx_line,
  output logic o_rx_line
);
  initial o_rx_line = 1'b1;
  // Sends one frame, each bit held for rate clocks; the line idles high after it.
  task automatic send(input logic [7:0] d, input int rate, input int npar, input logic pb);
    logic [10:0] fr;
    fr = (npar != 0) ? {1'b1, pb, d, 1'b0} : {2'b11, d, 1'b0};
    for (int i = 0; i < 10 + npar; i++) begin
      @(posedge i_clk_sys);
      #1;
      o_rx_line = fr[i];
      repeat (rate - 1) @(posedge i_clk_sys);
    end
    repeat (rate) @(posedge i_clk_sys);
  endtask : send
  // Waits a bounded time for a start bit, then samples eight data bits mid-bit.
  task automatic recv(input int rate, output logic [7:0] d);
    int k;
    k = 0;
    d = 8'h00;
    while (i_tx_line !== 1'b0 && k < 400) begin
      @(posedge i_clk_sys);
      #1;
      k++;
    end
    repeat (rate / 2) @(posedge i_clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (rate) @(posedge i_clk_sys);
      #1;
      d[i] = i_tx_line;
    end
  endtask : recv
endmodule : bsap_term

`default_nettype wire

// [test/test_bit_addressed_async_serial_port.sv]
`timescale 1ns/1ps
`default_nettype none

module test_bit_addressed_async_serial_port;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic i_cru_wr = 1'b0;
  logic i_cru_wdata = 1'b0;
  logic [11:0] i_cru_addr = 12'h000;
  logic o_cru_rdata;
  logic i_rx_line;
  logic o_tx_line;
  logic o_rts;
  int n_mismatch = 0;
  int checked = 0;
  logic [10:0] v;
  logic [7:0] c;
  always #2.5 i_clk_sys = ~i_clk_sys;
  bsap_port dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_cru_addr(i_cru_addr),
    .i_cru_wr(i_cru_wr), .i_cru_wdata(i_cru_wdata), .o_cru_rdata(o_cru_rdata),
    .i_rx_line(i_rx_line), .o_tx_line(o_tx_line), .o_rts(o_rts));
  bsap_term term (.i_clk_sys(i_clk_sys), .i_tx_line(o_tx_line), .o_rx_line(i_rx_line));
  task automatic wr(input int b, input logic [10:0] x, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk_sys);
      #1;
      i_cru_addr = 12'h800 + 12'(2 * (b + i));
      i_cru_wdata = x[i];
      i_cru_wr = 1'b1;
      @(posedge i_clk_sys);
      #1;
      i_cru_wr = 1'b0;
    end
  endtask : wr
  task automatic rd(input int b, input int n, output logic [10:0] x);
    x = 11'h000;
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk_sys);
      #1;
      i_cru_addr = 12'h800 + 12'(2 * (b + i));
      repeat (2) @(posedge i_clk_sys);
      #1;
      x[i] = o_cru_rdata;
    end
  endtask : rd
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge i_clk_sys);
    #1;
    i_resetn = 1'b1;
    rd(0, 8, v);
    chk(v, 11'h000);
    rd(9, 9, v);
    chk(v, 11'h140);
    chk({10'h000, o_tx_line}, 11'h001);
    $display("test reset done");
    wr(11, 11'h003, 2);
    wr(0, 11'h006, 11);
    wr(0, 11'h004, 11);
    wr(16, 11'h001, 1);
    chk({10'h000, o_rts}, 11'h001);
    wr(48, 11'h000, 1);
    chk({10'h000, o_rts}, 11'h001);
    rd(32, 1, v);
    chk(v, 11'h000);
    $display("test window done");
    fork
      term.recv(4, c);
      wr(0, 11'h055, 8);
    join
    chk({3'h0, c}, 11'h055);
    repeat (8) @(posedge i_clk_sys);
    rd(17, 1, v);
    chk(v, 11'h001);
    $display("test transmit done");
    term.send(8'ha5, 6, 0, 1'b0);
    rd(0, 8, v);
    chk(v, 11'h0a5);
    rd(16, 1, v);
    chk(v, 11'h001);
    // While the second character is in its data bits, both detect flags stand.
    fork
      term.send(8'h3c, 6, 0, 1'b0);
      begin
        repeat (20) @(posedge i_clk_sys);
        rd(13, 2, v);
      end
    join
    chk(v, 11'h003);
    rd(9, 4, v);
    chk(v, 11'h005);
    rd(0, 8, v);
    chk(v, 11'h03c);
    wr(18, 11'h000, 1);
    rd(9, 8, v);
    chk(v, 11'h040);
    $display("test receive done");
    wr(14, 11'h001, 1);
    wr(0, 11'h023, 8);
    term.send(8'h3c, 6, 1, 1'b1);
    rd(9, 4, v);
    chk(v, 11'h003);
    $display("test parity done");
    // Control and receive rate flagged together: control must load first.
    wr(12, 11'h005, 3);
    wr(0, 11'h031, 8);
    wr(0, 11'h004, 11);
    wr(18, 11'h000, 1);
    // Loop-back with six data bits and odd parity; the terminal holds the pin idle.
    wr(15, 11'h001, 1);
    wr(0, 11'h02a, 8);
    repeat (60) @(posedge i_clk_sys);
    rd(0, 8, v);
    chk(v, 11'h02a);
    rd(9, 8, v);
    chk(v, 11'h0c0);
    wr(15, 11'h000, 1);
    $display("test loop-back done");
    wr(17, 11'h001, 1);
    chk({10'h000, o_tx_line}, 11'h000);
    wr(17, 11'h000, 1);
    chk({10'h000, o_tx_line}, 11'h001);
    wr(31, 11'h001, 1);
    @(posedge i_clk_sys);
    #1;
    chk({10'h000, o_rts}, 11'h000);
    rd(9, 9, v);
    chk(v, 11'h140);
    $display("test break and reset done");
    give_verdict();
  end
endmodule : test_bit_addressed_async_serial_port

bind bsap_port bsap_chk u_chk (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
  .i_cru_addr(i_cru_addr), .i_cru_wr(i_cru_wr), .i_cru_wdata(i_cru_wdata),
  .o_cru_rdata(o_cru_rdata), .i_rx_line(i_rx_line), .o_tx_line(o_tx_line), .o_rts(o_rts));

`default_nettype wire
